// ===== verilog/tjlam_monitor.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tjlam_monitor #(
   parameter int LINKS = tjlam_pkg::LINKS
) (
   input  wire logic                                  pclk,
   input  wire logic                                  presetn,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [tjlam_pkg::ADDR_W-1:0]          paddr,
   input  wire logic [tjlam_pkg::DATA_W-1:0]          pwdata,
   output logic      [tjlam_pkg::DATA_W-1:0]          prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   input  wire tjlam_pkg::tjlam_rx_t [LINKS-1:0]      rx_link,
   output logic                                       int_n
);
   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [tjlam_pkg::ALM_N-1:0] alarm_st  [LINKS];
   logic [tjlam_pkg::ALM_N-1:0] irq_en_ff [LINKS];
   logic [tjlam_pkg::ALM_N-1:0] flag_ff   [LINKS];
   logic [tjlam_pkg::REG_W-1:0] thr_ff    [LINKS][tjlam_pkg::THR_N];
   tjlam_pkg::tjlam_fmt_t       fmt_ff    [LINKS];

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic [9:0]                  reg_index;
   logic [1:0]                  sel_link;
   logic [7:0]                  sel_reg;
   logic                        access;
   logic                        wr_go;
   logic [tjlam_pkg::DATA_W-1:0] nxt_rdata;
   logic                        nxt_err;
   logic                        irq_any;

   assign reg_index = paddr[11:2];
   assign sel_link  = reg_index[9:8];
   assign sel_reg   = reg_index[7:0];
   assign access    = psel & penable & ~pready;
   assign wr_go     = psel & penable & pready & pwrite & ~nxt_err;

   always_comb
   begin
      nxt_rdata = '0;
      nxt_err   = 1'b0;
      case (sel_reg)
         tjlam_pkg::IDX_STATE:
            nxt_rdata = 32'(alarm_st[sel_link]);
         tjlam_pkg::IDX_IRQ_EN:
            nxt_rdata = 32'(irq_en_ff[sel_link]);
         tjlam_pkg::IDX_FLAGS:
            nxt_rdata = 32'(flag_ff[sel_link]);
         tjlam_pkg::IDX_RED_DEC:
            nxt_rdata = 32'(thr_ff[sel_link][tjlam_pkg::THR_RED_DEC]);
         tjlam_pkg::IDX_RED_CLR:
            nxt_rdata = 32'(thr_ff[sel_link][tjlam_pkg::THR_RED_CLR]);
         tjlam_pkg::IDX_YEL_DEC:
            nxt_rdata = 32'(thr_ff[sel_link][tjlam_pkg::THR_YEL_DEC]);
         tjlam_pkg::IDX_YEL_CLR:
            nxt_rdata = 32'(thr_ff[sel_link][tjlam_pkg::THR_YEL_CLR]);
         tjlam_pkg::IDX_BLUE_DEC:
            nxt_rdata = 32'(thr_ff[sel_link][tjlam_pkg::THR_BLUE_DEC]);
         tjlam_pkg::IDX_BLUE_CLR:
            nxt_rdata = 32'(thr_ff[sel_link][tjlam_pkg::THR_BLUE_CLR]);
         tjlam_pkg::IDX_FORMAT:
            nxt_rdata = 32'(fmt_ff[sel_link]);
         default:
            nxt_err = 1'b1;
      endcase
   end

   // One wait state: read data and error are latched in the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= access;
         pslverr <= access & nxt_err;
         if (access)
            prdata <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // Interrupt output
   // ----------------------------------------
   always_comb
   begin
      irq_any = 1'b0;
      for (int k = 0; k < LINKS; k++)
         irq_any = irq_any | (|(flag_ff[k] & irq_en_ff[k]));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_n <= 1'b1;
      else
         int_n <= ~irq_any;
   end

   // ----------------------------------------
   // Per-link monitor
   // ----------------------------------------
   for (genvar i = 0; i < LINKS; i++)
   begin : g_link
      tjlam_pkg::tjlam_rx_t                rx;
      logic                                link_hit;
      logic [tjlam_pkg::FCNT_W-1:0]        frame_cnt_ff;
      logic [tjlam_pkg::CNT_W-1:0]         zero_cnt_ff;
      logic [tjlam_pkg::CNT_W-1:0]         yel_cnt_ff;
      logic [15:0]                         dl_sh_ff;
      logic                                sync_all_ff;
      logic                                nosync_all_ff;
      logic [tjlam_pkg::ALM_N-1:0]         prev_st_ff;
      logic                                win_end;
      logic                                zero_ev;
      logic                                yel_ev;
      logic                                yel_decl;
      logic                                blue_decl;
      logic                                win_sync;
      logic                                win_nosync;
      logic [tjlam_pkg::PCNT_W-1:0]        red_clr_win;

      assign rx       = rx_link[i];
      assign link_hit = wr_go & (sel_link == 2'(i));

      // Software-written configuration
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            irq_en_ff[i] <= '0;
            fmt_ff[i]    <= tjlam_pkg::FMT_T1_SF;
         end
         else if (link_hit)
         begin
            if (sel_reg == tjlam_pkg::IDX_IRQ_EN)
               irq_en_ff[i] <= pwdata[tjlam_pkg::ALM_N-1:0];
            if (sel_reg == tjlam_pkg::IDX_FORMAT)
               fmt_ff[i] <= tjlam_pkg::tjlam_fmt_t'(pwdata[2:0]);
         end
      end

      for (genvar t = 0; t < tjlam_pkg::THR_N; t++)
      begin : g_thr
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               thr_ff[i][t] <= tjlam_pkg::THR_RST[t];
            else if (link_hit && sel_reg == tjlam_pkg::IDX_RED_DEC + 8'(t))
               thr_ff[i][t] <= pwdata[tjlam_pkg::REG_W-1:0];
         end
      end

      // Fixed 40 ms window of received frames
      assign win_end = rx.frame_start &&
                       frame_cnt_ff == tjlam_pkg::FCNT_W'(tjlam_pkg::WIN_FRAMES - 1);

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            frame_cnt_ff <= '0;
         else if (win_end)
            frame_cnt_ff <= '0;
         else if (rx.frame_start)
            frame_cnt_ff <= frame_cnt_ff + tjlam_pkg::FCNT_W'(1);
      end

      // Sync held or lost for the whole window
      assign win_sync   = sync_all_ff & rx.frame_sync;
      assign win_nosync = nosync_all_ff & ~rx.frame_sync;

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            sync_all_ff   <= 1'b0;
            nosync_all_ff <= 1'b0;
         end
         else if (win_end)
         begin
            sync_all_ff   <= 1'b1;
            nosync_all_ff <= 1'b1;
         end
         else
         begin
            sync_all_ff   <= win_sync;
            nosync_all_ff <= win_nosync;
         end
      end

      // Pattern events
      assign zero_ev = rx.bit_valid & ~rx.bit_val;

      always_comb
      begin
         yel_ev = 1'b0;
         case (fmt_ff[i])
            tjlam_pkg::FMT_T1_SF,
            tjlam_pkg::FMT_SLC96:
               yel_ev = rx.bit_valid & ~rx.is_fbit & rx.bit_val &
                        (rx.bit_pos == tjlam_pkg::SF_BIT_POS);
            tjlam_pkg::FMT_T1_ESF:
               yel_ev = rx.bit_valid & rx.is_dl &
                        ({dl_sh_ff[14:0], rx.bit_val} == tjlam_pkg::ESF_PATTERN);
            tjlam_pkg::FMT_T1_DM:
               yel_ev = rx.bit_valid & rx.bit_val & (rx.chan == tjlam_pkg::DM_CHAN) &
                        (rx.bit_pos == tjlam_pkg::DM_BIT_POS);
            tjlam_pkg::FMT_J1_SF:
               yel_ev = rx.bit_valid & rx.is_fbit & ~rx.bit_val &
                        (rx.frame_num == tjlam_pkg::J1SF_FRAME);
            tjlam_pkg::FMT_J1_ESF:
               yel_ev = rx.bit_valid & rx.is_dl & ~rx.bit_val;
            default:
               yel_ev = 1'b0;
         endcase
      end

      // Window verdicts; the blue and yellow clear criteria are the exact complement of declare
      always_comb
      begin
         blue_decl = zero_cnt_ff < tjlam_pkg::BLUE_ZEROS_LT;
         case (fmt_ff[i])
            tjlam_pkg::FMT_T1_SF,
            tjlam_pkg::FMT_SLC96:
               yel_decl = yel_cnt_ff < tjlam_pkg::SF_ONES_LT;
            tjlam_pkg::FMT_T1_ESF:
               yel_decl = yel_cnt_ff > tjlam_pkg::ESF_PAT_GT;
            tjlam_pkg::FMT_T1_DM:
               yel_decl = yel_cnt_ff < tjlam_pkg::DM_ONES_LT;
            tjlam_pkg::FMT_J1_SF:
               yel_decl = yel_cnt_ff < tjlam_pkg::J1SF_ZEROS_LT;
            tjlam_pkg::FMT_J1_ESF:
               yel_decl = yel_cnt_ff < tjlam_pkg::J1ESF_ZEROS_LT;
            default:
               yel_decl = 1'b0;
         endcase
      end

      // Counters saturate so a long all-zero window cannot wrap
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            zero_cnt_ff <= '0;
            yel_cnt_ff  <= '0;
            dl_sh_ff    <= '0;
         end
         else
         begin
            if (win_end)
               zero_cnt_ff <= tjlam_pkg::CNT_W'(zero_ev);
            else if (zero_ev && zero_cnt_ff != '1)
               zero_cnt_ff <= zero_cnt_ff + tjlam_pkg::CNT_W'(1);
            if (win_end)
               yel_cnt_ff <= tjlam_pkg::CNT_W'(yel_ev);
            else if (yel_ev && yel_cnt_ff != '1)
               yel_cnt_ff <= yel_cnt_ff + tjlam_pkg::CNT_W'(1);
            if (rx.bit_valid && rx.is_dl)
               dl_sh_ff <= {dl_sh_ff[14:0], rx.bit_val};
         end
      end

      // ----------------------------------------
      // Persistence
      // ----------------------------------------
      assign red_clr_win = tjlam_pkg::PCNT_W'(thr_ff[i][tjlam_pkg::THR_RED_CLR]) *
                           tjlam_pkg::PCNT_W'(tjlam_pkg::RED_CLR_MULT);

      tjlam_persist #(.CW(tjlam_pkg::PCNT_W)) u_blue (
         .pclk     (pclk),
         .presetn  (presetn),
         .win_end  (win_end),
         .decl_hit (blue_decl),
         .clr_hit  (~blue_decl),
         .decl_thr (tjlam_pkg::PCNT_W'(thr_ff[i][tjlam_pkg::THR_BLUE_DEC])),
         .clr_thr  (tjlam_pkg::PCNT_W'(thr_ff[i][tjlam_pkg::THR_BLUE_CLR])),
         .alarm_ff (alarm_st[i][tjlam_pkg::BIT_BLUE])
      );

      // Out-of-sync windows are skipped, so yellow holds while unframed
      tjlam_persist #(.CW(tjlam_pkg::PCNT_W)) u_yel (
         .pclk     (pclk),
         .presetn  (presetn),
         .win_end  (win_end & win_sync),
         .decl_hit (yel_decl),
         .clr_hit  (~yel_decl),
         .decl_thr (tjlam_pkg::PCNT_W'(thr_ff[i][tjlam_pkg::THR_YEL_DEC])),
         .clr_thr  (tjlam_pkg::PCNT_W'(thr_ff[i][tjlam_pkg::THR_YEL_CLR])),
         .alarm_ff (alarm_st[i][tjlam_pkg::BIT_YEL])
      );

      // Partly synced windows match neither side and restart the run
      tjlam_persist #(.CW(tjlam_pkg::PCNT_W)) u_red (
         .pclk     (pclk),
         .presetn  (presetn),
         .win_end  (win_end),
         .decl_hit (win_nosync),
         .clr_hit  (win_sync),
         .decl_thr (tjlam_pkg::PCNT_W'(thr_ff[i][tjlam_pkg::THR_RED_DEC])),
         .clr_thr  (red_clr_win),
         .alarm_ff (alarm_st[i][tjlam_pkg::BIT_RED])
      );

      // ----------------------------------------
      // Change flags: a new edge beats a same-cycle clear
      // ----------------------------------------
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            prev_st_ff <= '0;
            flag_ff[i] <= '0;
         end
         else
         begin
            prev_st_ff <= alarm_st[i];
            flag_ff[i] <= (flag_ff[i] &
                           ~((link_hit && sel_reg == tjlam_pkg::IDX_FLAGS) ?
                             pwdata[tjlam_pkg::ALM_N-1:0] : '0)) |
                          (alarm_st[i] ^ prev_st_ff);
         end
      end
   end
endmodule
`default_nettype wire

// ===== verilog/tjlam_pkg.sv
`default_nettype none
package tjlam_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int LINKS   = 4;
   localparam int ADDR_W  = 12;
   localparam int DATA_W  = 32;
   localparam int REG_W   = 8;
   localparam int CNT_W   = 8;
   localparam int PCNT_W  = 10;
   localparam int THR_N   = 6;

   // ----------------------------------------
   // Register indices (byte address = 4 x index, link in index bits 9:8)
   // ----------------------------------------
   localparam logic [7:0] IDX_STATE    = 8'hB9;
   localparam logic [7:0] IDX_IRQ_EN   = 8'hBA;
   localparam logic [7:0] IDX_FLAGS    = 8'hBB;
   localparam logic [7:0] IDX_RED_DEC  = 8'hBC;
   localparam logic [7:0] IDX_RED_CLR  = 8'hBD;
   localparam logic [7:0] IDX_YEL_DEC  = 8'hBE;
   localparam logic [7:0] IDX_YEL_CLR  = 8'hBF;
   localparam logic [7:0] IDX_BLUE_DEC = 8'hC0;
   localparam logic [7:0] IDX_BLUE_CLR = 8'hC1;
   localparam logic [7:0] IDX_FORMAT   = 8'hC8;

   // Slots of the threshold array, in index order
   localparam int THR_RED_DEC  = 0;
   localparam int THR_RED_CLR  = 1;
   localparam int THR_YEL_DEC  = 2;
   localparam int THR_YEL_CLR  = 3;
   localparam int THR_BLUE_DEC = 4;
   localparam int THR_BLUE_CLR = 5;
   localparam logic [THR_N-1:0][REG_W-1:0] THR_RST =
      {8'h3F, 8'h3F, 8'h0A, 8'h0A, 8'h7F, 8'h3F};

   // Bit positions in state, enable and change-flag registers
   localparam int BIT_RED  = 0;
   localparam int BIT_YEL  = 1;
   localparam int BIT_BLUE = 2;
   localparam int ALM_N    = 3;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int FRAME_US     = 125;
   localparam int WINDOW_MS    = 40;
   localparam int RED_CLR_MS   = 120;
   localparam int WIN_FRAMES   = WINDOW_MS * 1000 / FRAME_US;
   localparam int RED_CLR_MULT = RED_CLR_MS / WINDOW_MS;
   localparam int FCNT_W       = $clog2(WIN_FRAMES);

   // ----------------------------------------
   // Pattern criteria
   // ----------------------------------------
   localparam logic [CNT_W-1:0] BLUE_ZEROS_LT  = 8'h3D;
   localparam logic [CNT_W-1:0] SF_ONES_LT     = 8'h4D;
   localparam logic [CNT_W-1:0] ESF_PAT_GT     = 8'h07;
   localparam logic [CNT_W-1:0] DM_ONES_LT     = 8'h04;
   localparam logic [CNT_W-1:0] J1SF_ZEROS_LT  = 8'h04;
   localparam logic [CNT_W-1:0] J1ESF_ZEROS_LT = 8'h03;
   localparam logic [15:0]      ESF_PATTERN    = 16'hFF00;
   localparam logic [2:0]       SF_BIT_POS     = 3'h1;
   localparam logic [2:0]       DM_BIT_POS     = 3'h5;
   localparam logic [4:0]       DM_CHAN        = 5'h17;
   localparam logic [4:0]       J1SF_FRAME     = 5'h0C;

   typedef enum logic [2:0] {
      FMT_T1_SF,
      FMT_SLC96,
      FMT_T1_ESF,
      FMT_T1_DM,
      FMT_J1_SF,
      FMT_J1_ESF
   } tjlam_fmt_t;

   // Received-bit strobe from the framer, one per link
   typedef struct packed {
      logic       frame_sync;
      logic       frame_start;
      logic       bit_valid;
      logic       bit_val;
      logic [4:0] chan;
      logic [2:0] bit_pos;
      logic       is_fbit;
      logic [4:0] frame_num;
      logic       is_dl;
   } tjlam_rx_t;
endpackage
`default_nettype wire

// ===== verilog/tjlam_persist.sv
`timescale 1ns/1ps
`default_nettype none
module tjlam_persist #(
   parameter int CW = 10
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          win_end,
   input  wire logic          decl_hit,
   input  wire logic          clr_hit,
   input  wire logic [CW-1:0] decl_thr,
   input  wire logic [CW-1:0] clr_thr,
   output logic               alarm_ff
);
   logic [CW-1:0] run_ff;
   logic [CW-1:0] nxt_run;
   logic [CW-1:0] thr;
   logic          hit;

   always_comb
   begin
      hit     = alarm_ff ? clr_hit : decl_hit;
      thr     = alarm_ff ? clr_thr : decl_thr;
      nxt_run = (run_ff == '1) ? run_ff : run_ff + CW'(1);
   end

   // Any window that misses the criterion restarts the run
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_ff <= '0;
      else if (win_end)
         run_ff <= (hit && nxt_run < thr) ? nxt_run : '0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         alarm_ff <= 1'b0;
      else if (win_end && hit && nxt_run >= thr)
         alarm_ff <= ~alarm_ff;
   end
endmodule
`default_nettype wire

// ===== tb/tjlam_monitor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tjlam_monitor_properties #(
   parameter int LINKS = tjlam_pkg::LINKS
) (
   input wire logic                                  pclk,
   input wire logic                                  presetn,
   input wire logic                                  psel,
   input wire logic                                  penable,
   input wire logic                                  pwrite,
   input wire logic [tjlam_pkg::ADDR_W-1:0]          paddr,
   input wire logic [tjlam_pkg::DATA_W-1:0]          pwdata,
   input wire logic [tjlam_pkg::DATA_W-1:0]          prdata,
   input wire logic                                  pready,
   input wire logic                                  pslverr,
   input wire tjlam_pkg::tjlam_rx_t [LINKS-1:0]      rx_link,
   input wire logic                                  int_n
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic       fs_any;
   logic       acc;
   logic       wacc;
   logic       racc;
   logic [7:0] idx;
   always_comb
   begin
      fs_any = 1'b0;
      for (int i = 0; i < LINKS; i++)
         fs_any = fs_any | rx_link[i].frame_start;
   end
   assign acc  = psel && penable && pready;
   assign wacc = acc && pwrite;
   assign racc = acc && !pwrite;
   assign idx  = paddr[9:2];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_rst_quiet;
      $rose(presetn) |-> int_n && (prdata == '0);
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs not idle after reset");
   property p_state_bits;
      racc && idx == tjlam_pkg::IDX_STATE |-> prdata[31:3] == '0 && !pslverr;
   endproperty
   a_state_bits: assert property (p_state_bits)
      else $error("state read has stray bits");
   property p_en_bits;
      racc && idx == tjlam_pkg::IDX_IRQ_EN |-> prdata[31:3] == '0 && !pslverr;
   endproperty
   a_en_bits: assert property (p_en_bits)
      else $error("enable read has stray bits");
   property p_flag_bits;
      racc && idx == tjlam_pkg::IDX_FLAGS |-> prdata[31:3] == '0 && !pslverr;
   endproperty
   a_flag_bits: assert property (p_flag_bits)
      else $error("flag read has stray bits");
   property p_thr_bits;
      racc && idx inside {[8'hBC:8'hC1]} |-> prdata[31:8] == '0 && !pslverr;
   endproperty
   a_thr_bits: assert property (p_thr_bits)
      else $error("threshold read is not eight bits");
   property p_mask_off;
      wacc && idx == tjlam_pkg::IDX_IRQ_EN && pwdata[2:0] == 3'h0 |-> ##[1:2] int_n;
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("interrupt stays with all enables off");
   // A falling interrupt must follow a frame start on any link or any APB write
   property p_int_fall;
      $fell(int_n) |-> $past(fs_any, 2) || $past(fs_any, 3) || $past(wacc, 1) || $past(wacc, 2);
   endproperty
   a_int_fall: assert property (p_int_fall)
      else $error("interrupt raised without a cause");
   property p_int_rise;
      $rose(int_n) |-> $past(wacc, 1) || $past(wacc, 2);
   endproperty
   a_int_rise: assert property (p_int_rise)
      else $error("interrupt dropped without a write");
   c_int: cover property ($fell(int_n));
   c_err: cover property (acc && pslverr);
   c_mask: cover property (wacc && idx == tjlam_pkg::IDX_IRQ_EN);
endmodule
bind tjlam_monitor tjlam_monitor_properties #(.LINKS(LINKS)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rx_link(rx_link), .int_n(int_n));
`default_nettype wire

// ===== tb/tjlam_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
// One frame every four cycles with one received bit on the Y-bit slot,
// so blue counts and T1 DM yellow counts see the same bit stream
module tjlam_framer_model (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 sync_on,
   input  wire logic                 bit_one,
   output var tjlam_pkg::tjlam_rx_t  rx
);
   logic [1:0] ph_ff;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ph_ff <= 2'h0;
      else
         ph_ff <= ph_ff + 2'h1;
   always_comb
   begin
      rx.frame_sync  = sync_on;
      rx.frame_start = (ph_ff == 2'h0);
      rx.bit_valid   = (ph_ff == 2'h2);
      // Line is not held outside the strobe, so it wanders
      rx.bit_val     = (ph_ff == 2'h2) ? bit_one : ph_ff[0];
      rx.chan        = tjlam_pkg::DM_CHAN;
      rx.bit_pos     = tjlam_pkg::DM_BIT_POS;
      rx.is_fbit     = 1'b0;
      rx.frame_num   = 5'h01;
      rx.is_dl       = 1'b0;
   end
endmodule
`default_nettype wire

// ===== tb/test_tjlam_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      n_checks++; \
      if ((a) !== (e)) \
      begin \
         fails++; \
         $display("[ERR] %0t got %0h expected %0h", $time, (a), (e)); \
      end \
   end
module test_tjlam_monitor;
   localparam int WIN = tjlam_pkg::WIN_FRAMES * 4;
   localparam logic [7:0] DEFS [6] = '{8'h3F, 8'h7F, 8'h0A, 8'h0A, 8'h3F, 8'h3F};
   localparam logic [7:0] CFG  [6] = '{8'h02, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01};
   logic                                      pclk;
   logic                                      presetn;
   logic                                      psel;
   logic                                      penable;
   logic                                      pwrite;
   logic [11:0]                               paddr;
   logic [31:0]                               pwdata;
   logic [31:0]                               prdata;
   logic                                      pready;
   logic                                      pslverr;
   logic                                      int_n;
   logic                                      sync_on;
   logic                                      bit_one;
   logic [31:0]                               rd;
   logic                                      err;
   tjlam_pkg::tjlam_rx_t                      rx;
   tjlam_pkg::tjlam_rx_t [tjlam_pkg::LINKS-1:0] rx_link;
   int                                        fails;
   int                                        n_checks;
   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   assign rx_link = {tjlam_pkg::LINKS{rx}};
   tjlam_framer_model tjlam_framer_model_inst (.pclk(pclk), .presetn(presetn),
      .sync_on(sync_on), .bit_one(bit_one), .rx(rx));
   tjlam_monitor tjlam_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_link(rx_link),
      .int_n(int_n));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [1:0] lk, input logic [7:0] idx,
                      input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {lk, idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk_rd(input logic [1:0] lk, input logic [7:0] idx, input logic [31:0] ex);
      apb(1'b0, lk, idx, 32'h0);
      `CHK(rd, ex)
      `CHK(err, 1'b0)
   endtask
   // Windows are fixed frame counts, so waiting whole windows is exact
   task automatic wins(input int n);
      repeat (n * WIN) @(posedge pclk);
   endtask
   task automatic int_is(input logic ex);
      repeat (3) @(posedge pclk);
      `CHK(int_n, ex)
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, reset, watchdog
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial
   begin
      repeat (30 * WIN) @(posedge pclk);
      fails++;
      print_verdict();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      fails = 0;
      n_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sync_on = 1'b1;
      bit_one = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h0);
      chk_rd(2'h0, tjlam_pkg::IDX_IRQ_EN, 32'h0);
      chk_rd(2'h0, tjlam_pkg::IDX_FLAGS, 32'h0);
      for (int i = 0; i < 6; i++)
         chk_rd(2'h0, 8'(tjlam_pkg::IDX_RED_DEC + i), 32'(DEFS[i]));
      apb(1'b0, 2'h0, 8'h00, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      apb(1'b1, 2'h0, tjlam_pkg::IDX_STATE, 32'h7);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h0);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_FORMAT, 32'(tjlam_pkg::FMT_T1_DM));
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, 2'h0, 8'(tjlam_pkg::IDX_RED_DEC + i), 32'(CFG[i]));
         chk_rd(2'h0, 8'(tjlam_pkg::IDX_RED_DEC + i), 32'(CFG[i]));
      end
      apb(1'b1, 2'h0, tjlam_pkg::IDX_IRQ_EN, 32'h4);
      // All ones in sync: blue after two windows, yellow held clear
      wins(3);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h4);
      chk_rd(2'h0, tjlam_pkg::IDX_FLAGS, 32'h4);
      int_is(1'b0);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_IRQ_EN, 32'h0);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_FLAGS, 32'h7);
      int_is(1'b1);
      chk_rd(2'h0, tjlam_pkg::IDX_FLAGS, 32'h0);
      // All zeros: blue clears, yellow declares, both flags set but masked
      @(posedge pclk);
      bit_one <= 1'b0;
      wins(2);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h2);
      chk_rd(2'h0, tjlam_pkg::IDX_FLAGS, 32'h6);
      int_is(1'b1);
      chk_rd(2'h1, tjlam_pkg::IDX_STATE, 32'h0);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_IRQ_EN, 32'h2);
      int_is(1'b0);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_FLAGS, 32'h7);
      // Out of sync with ones: red declares, yellow must not be judged
      @(posedge pclk);
      sync_on <= 1'b0;
      bit_one <= 1'b1;
      wins(3);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h7);
      chk_rd(2'h0, tjlam_pkg::IDX_FLAGS, 32'h5);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_FLAGS, 32'h7);
      // Back in sync: red needs three whole windows, one is not enough
      @(posedge pclk);
      sync_on <= 1'b1;
      wins(2);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h5);
      wins(3);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h4);
      // No slot matches in these formats: SF and J1 ESF declare, ESF clears
      apb(1'b1, 2'h0, tjlam_pkg::IDX_FORMAT, 32'(tjlam_pkg::FMT_T1_SF));
      wins(2);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h6);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_FORMAT, 32'(tjlam_pkg::FMT_T1_ESF));
      wins(2);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h4);
      apb(1'b1, 2'h0, tjlam_pkg::IDX_FORMAT, 32'(tjlam_pkg::FMT_J1_ESF));
      wins(2);
      chk_rd(2'h0, tjlam_pkg::IDX_STATE, 32'h6);
      print_verdict();
   end
endmodule
`default_nettype wire
